/* ctp_pkg.sv */
// Package for the counter/timer/tach setup menu sequencer
package ctp_pkg;

    // ****************************************************************
    // Mode codes read from the mode-select pins
    // ****************************************************************
    localparam logic [3:0] MODE_TIMER = 4'h0;
    localparam logic [3:0] MODE_TACH = 4'hB;
    localparam logic [3:0] MODE_COUNTER = 4'hC;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_SETTING = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_MULT = 8'h0C;

    // ****************************************************************
    // Reset values and limits
    // ****************************************************************
    localparam logic [3:0] RANGE_RESET = 4'h0;
    localparam logic [3:0] RANGE_LAST = 4'h9;
    localparam logic [3:0] DIGIT_LAST = 4'h9;
    localparam logic [2:0] POINT_RESET = 3'h4;
    localparam logic [2:0] TBASE_DEFAULT = 3'h1;
    localparam logic [2:0] TBASE_ENTRY = 3'h6;
    localparam logic [2:0] DIGIT_TOP = 3'h4;

    // ****************************************************************
    // Blink timing: 2 Hz toggles every 250 ms
    // ****************************************************************
    localparam int CLK_HZ = 25000000;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;

    // Menu states, one-hot
    typedef enum logic [4:0] {
        CTP_RUN = 5'b00001,
        CTP_RANGE = 5'b00010,
        CTP_DIGITS = 5'b00100,
        CTP_POINT = 5'b01000,
        CTP_TBASE = 5'b10000
    } ctp_state_t;

    // Programmed settings as one carrier
    typedef struct packed {
        logic [3:0] range;
        logic [2:0] point;
        logic [2:0] tbase;
        logic [19:0] mult;
    } ctp_setting_t;

endpackage : ctp_pkg

/* ctp_menu.sv */
// Setup menu sequencer for a six-digit counter, timer and tachometer
`timescale 1ns/100ps
module ctp_menu (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [3:0] mode_select_pins,
    input wire logic setup_menu_input_n,
    input wire logic step_input_n,
    input wire logic slow_signal_input,
    input wire logic fast_signal_input,
    // Outputs to counting and display logic
    output ctp_pkg::ctp_setting_t setting,
    output logic count_pulse,
    output logic timer_run,
    output logic in_menu,
    output logic blink_on,
    output logic [2:0] blink_digit,
    output logic rate_enable
);
    import ctp_pkg::*;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] mode_sync1;
    logic [3:0] mode_sync2;
    logic pgm_prev;
    logic step_prev;
    logic sig_prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 4'hF;
            sync2 <= 4'hF;
            mode_sync1 <= 4'h0;
            mode_sync2 <= 4'h0;
        end else if (clk_en) begin
            sync1 <= {setup_menu_input_n, step_input_n, slow_signal_input, fast_signal_input};
            sync2 <= sync1;
            mode_sync1 <= mode_select_pins;
            mode_sync2 <= mode_sync1;
        end
    end

    logic pgm_s;
    logic step_s;
    logic slow_s;
    logic fast_s;
    assign pgm_s = sync2[3];
    assign step_s = sync2[2];
    assign slow_s = sync2[1];
    assign fast_s = sync2[0];

    // Falling edge seen once; a held low level gives nothing more
    logic pgm_pulse;
    logic step_pulse;
    assign pgm_pulse = pgm_prev & ~pgm_s;
    assign step_pulse = step_prev & ~step_s;

    // ****************************************************************
    // Mode capture at power-up
    // ****************************************************************
    logic [3:0] mode;
    logic mode_taken;
    logic [1:0] settle;
    // Pins read once, after the synchroniser has filled
    // power-up mode read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= MODE_TIMER;
            mode_taken <= 1'b0;
            settle <= 2'h0;
        end else if (clk_en && !mode_taken) begin
            settle <= settle + 2'h1;
            if (settle == 2'h3) begin
                mode <= mode_sync2;
                mode_taken <= 1'b1;
            end
        end
    end

    logic is_timer;
    logic is_tach;
    assign is_timer = (mode == MODE_TIMER);
    assign is_tach = (mode == MODE_TACH);

    // ****************************************************************
    // Menu state machine and settings
    // ****************************************************************
    ctp_state_t state;
    logic used_pgm;
    logic [2:0] digit;
    logic [3:0] cur_digit;
    assign cur_digit = setting.mult[digit*4 +: 4];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= CTP_RUN;
            setting.range <= RANGE_RESET;
            setting.point <= POINT_RESET;
            setting.tbase <= TBASE_DEFAULT;
            setting.mult <= 20'h0;
            used_pgm <= 1'b0;
            digit <= 3'h0;
            pgm_prev <= 1'b1;
            step_prev <= 1'b1;
        end else if (clk_en) begin
            pgm_prev <= pgm_s;
            step_prev <= step_s;
            case (state)
                CTP_RUN: begin
                    if (pgm_pulse && mode_taken) begin
                        used_pgm <= 1'b1;
                        if (is_timer) begin
                            state <= CTP_RANGE;
                        end else begin
                            state <= CTP_DIGITS;
                            digit <= 3'h0;
                            if (!used_pgm) begin
                                setting.mult <= 20'h0;
                            end
                        end
                    end
                end
                CTP_RANGE: begin
                    if (pgm_pulse) begin
                        state <= CTP_RUN;
                    end else if (step_pulse) begin
                        setting.range <= (setting.range == RANGE_LAST) ? 4'h0
                                         : setting.range + 4'h1;
                    end
                end
                CTP_DIGITS: begin
                    if (pgm_pulse) begin
                        if (digit == DIGIT_TOP) begin
                            state <= CTP_POINT;
                            setting.point <= POINT_RESET;
                        end else begin
                            digit <= digit + 3'h1;
                        end
                    end else if (step_pulse) begin
                        if (digit == DIGIT_TOP) begin
                            setting.mult[digit*4 +: 4] <= {3'h0, ~cur_digit[0]};
                        end else begin
                            setting.mult[digit*4 +: 4] <= (cur_digit == DIGIT_LAST) ? 4'h0
                                                          : cur_digit + 4'h1;
                        end
                    end
                end
                CTP_POINT: begin
                    if (pgm_pulse) begin
                        if (is_tach) begin
                            state <= CTP_TBASE;
                            setting.tbase <= TBASE_ENTRY;
                        end else begin
                            state <= CTP_RUN;
                        end
                    end else if (step_pulse) begin
                        setting.point <= setting.point + 3'h1;
                    end
                end
                CTP_TBASE: begin
                    if (pgm_pulse) begin
                        state <= CTP_RUN;
                    end else if (step_pulse) begin
                        setting.tbase <= setting.tbase + 3'h1;
                    end
                end
                default: begin
                    state <= CTP_RUN;
                end
            endcase
        end
    end

    // ****************************************************************
    // Menu checks
    // ****************************************************************
    // A program pulse taken in the run state
    sequence run_pgm_s;
        clk_en && state == CTP_RUN && pgm_pulse && mode_taken;
    endsequence
    // The same pulse, then one more enabled edge for the registered flag
    sequence menu_open_s;
        run_pgm_s ##1 clk_en;
    endsequence

    menu_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        menu_open_s |=> in_menu)
        else $error("menu flag not raised after a program pulse");

    range_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && state == CTP_RANGE && !pgm_pulse && step_pulse
            && setting.range == RANGE_LAST) |=> setting.range == 4'h0)
        else $error("timer range did not wrap to zero");

    top_digit_a: assert property (@(posedge pclk) disable iff (!presetn)
        setting.mult[19:16] <= 4'h1)
        else $error("highest digit left the values zero and one");

    point_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && state == CTP_DIGITS && pgm_pulse && digit == DIGIT_TOP)
            |=> (state == CTP_POINT && setting.point == POINT_RESET))
        else $error("point selection not entered at its start position");

    tbase_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && state == CTP_POINT && pgm_pulse && is_tach)
            |=> (state == CTP_TBASE && setting.tbase == TBASE_ENTRY))
        else $error("time base selection not entered at six seconds");

    first_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_pgm_s ##0 (!is_timer && !used_pgm) |=> setting.mult == 20'h0)
        else $error("multiplier not cleared on the first menu entry");

    pulse_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && step_pulse) |=> !step_pulse)
        else $error("step pulse detected on two enabled edges");

    // ****************************************************************
    // Blink timer for the selected digit
    // ****************************************************************
    logic [23:0] blink_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt <= 24'h0;
            blink_on <= 1'b0;
        end else if (clk_en) begin
            if (state != CTP_DIGITS) begin
                // Restart so each entry starts lit
                blink_cnt <= 24'h0;
                blink_on <= 1'b1;
            end else if (blink_cnt == 24'(BLINK_CYCLES - 1)) begin
                blink_cnt <= 24'h0;
                blink_on <= ~blink_on;
            end else begin
                blink_cnt <= blink_cnt + 24'h1;
            end
        end
    end

    // ****************************************************************
    // Signal edge choice and timer run decision
    // ****************************************************************
    logic sig_sel;
    logic rise_mode;
    // The unused input's level picks the edge; if both inputs move together the xor holds and nothing counts
    assign sig_sel = slow_s ? fast_s : (fast_s ? fast_s : slow_s);
    // edge swaps after programming
    // A high unused input inverts the xor, so its level and programming both pick the direction
    assign rise_mode = used_pgm;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_prev <= 1'b0;
            count_pulse <= 1'b0;
            timer_run <= 1'b0;
            in_menu <= 1'b0;
            blink_digit <= 3'h0;
            rate_enable <= 1'b0;
        end else if (clk_en) begin
            sig_prev <= fast_s ^ slow_s;
            count_pulse <= (state == CTP_RUN) && !is_timer &&
                           (rise_mode ? (!sig_prev && (fast_s ^ slow_s))
                                      : (sig_prev && !(fast_s ^ slow_s)));
            // stop only slow low, fast high
            timer_run <= is_timer && (state == CTP_RUN) && !(!slow_s && fast_s);
            in_menu <= (state != CTP_RUN);
            blink_digit <= digit;
            rate_enable <= is_tach && (setting.tbase != 3'h0);
        end
    end

    rate_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && setting.tbase == 3'h0) |=> !rate_enable)
        else $error("rate shown with a zero time base");

    timer_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && is_timer && state == CTP_RUN && !slow_s && fast_s) |=> !timer_run)
        else $error("timer runs with slow input low and fast input high");

    // ****************************************************************
    // APB slave, zero wait states
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    OFS_STATUS: prdata <= {20'h0, used_pgm, mode_taken, state, 1'b0, mode};
                    OFS_SETTING: prdata <= {22'h0, setting.tbase, setting.point, setting.range};
                    OFS_CONTROL: prdata <= 32'h0;
                    OFS_MULT: prdata <= {12'h0, setting.mult};
                    default: begin
                        prdata <= 32'h0;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Bus writes are accepted and ignored; settings come only from the pins
    logic unused_bus;
    assign unused_bus = pwrite ^ (|pwdata) ^ sig_sel;

endmodule : ctp_menu

/* ctp_pins_model.sv */
// Pin-level model of the switches and sensors that feed the menu block
`timescale 1ns/100ps
module ctp_pins_model (
    // Clock
    input wire logic pclk,
    // Pins toward the block
    output logic [3:0] mode_select_pins,
    output logic setup_menu_input_n,
    output logic step_input_n,
    output logic slow_signal_input,
    output logic fast_signal_input
);
    // Both pulse lines rest high, signal lines low
    initial begin
        mode_select_pins = 4'h0;
        setup_menu_input_n = 1'b1;
        step_input_n = 1'b1;
        slow_signal_input = 1'b0;
        fast_signal_input = 1'b0;
    end

    // brief low pulse
    // Held low two cycles so the synchroniser cannot miss it, then rest
    task automatic pulse(input logic setup_menu_input);
        @(posedge pclk);
        setup_menu_input_n <= !setup_menu_input;
        step_input_n <= setup_menu_input;
        repeat (2) @(posedge pclk);
        setup_menu_input_n <= 1'b1;
        step_input_n <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask : pulse

    // Level pins; the wait covers synchroniser and register delay
    task automatic set(input logic [3:0] mode, input logic slow, input logic fast);
        @(posedge pclk);
        mode_select_pins <= mode;
        slow_signal_input <= slow;
        fast_signal_input <= fast;
        repeat (6) @(posedge pclk);
    endtask : set
endmodule : ctp_pins_model

/* tb_top.sv */
// Self-checking bench for the setup menu sequencer
`timescale 1ns/100ps
module tb_top;
    import ctp_pkg::*;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic clk_en = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, count_pulse, timer_run, in_menu, blink_on, rate_enable;
    logic [2:0] blink_digit;
    ctp_setting_t setting;
    logic [3:0] mode_pins;
    logic pgm_n, step_n, slow, fast;
    int errors = 0;
    int checks = 0;
    int cycles = 0;

    // 25 MHz clock
    always #20 pclk = ~pclk;

    ctp_pins_model pins (.pclk(pclk), .mode_select_pins(mode_pins),
        .setup_menu_input_n(pgm_n), .step_input_n(step_n),
        .slow_signal_input(slow), .fast_signal_input(fast));

    ctp_menu dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_select_pins(mode_pins),
        .setup_menu_input_n(pgm_n), .step_input_n(step_n), .slow_signal_input(slow),
        .fast_signal_input(fast), .setting(setting), .count_pulse(count_pulse),
        .timer_run(timer_run), .in_menu(in_menu), .blink_on(blink_on),
        .blink_digit(blink_digit), .rate_enable(rate_enable));

    // Hang guard, far beyond the fewer than a thousand cycles the tests need
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    // APB read: setup, then access held until pready is sampled high
    task automatic apb_read(input logic [7:0] addr, output logic [31:0] data, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= addr;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        check("pready wait", n, 1);
        data = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_read

    // APB write: direction and data held with the request until pready is seen
    task automatic apb_write(input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        check("pready wait", n, 1);
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
    endtask : apb_write

    // reset after programming
    // Mode pins are read only after reset, so each mode gets a fresh reset
    task automatic restart(input logic [3:0] mode);
        @(posedge pclk);
        presetn <= 1'b0;
        pins.set(mode, 1'b0, 1'b0);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
    endtask : restart

    // Move the fast input to a level and count the pulses it produces
    task automatic count_edge(input logic other, input logic level, input int exp);
        int n;
        n = 0;
        fork
            pins.set(MODE_COUNTER, other, level);
            repeat (12) begin
                @(posedge pclk);
                n += (count_pulse === 1'b1);
            end
        join
        check("count_pulse", n, exp);
    endtask : count_edge

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_timer();
        logic [31:0] d;
        logic e;
        restart(MODE_TIMER);
        check("range", setting.range, RANGE_RESET);
        for (int i = 0; i < 4; i++) begin
            pins.set(MODE_TIMER, i[1], i[0]);
            check("timer_run", timer_run, !(!i[1] && i[0]));
        end
        pins.pulse(1'b1);
        check("in_menu", in_menu, 1'b1);
        check("range", setting.range, RANGE_RESET);
        for (int i = 1; i <= 13; i++) begin
            pins.pulse(1'b0);
            check("range", setting.range, i % 10);
        end
        pins.pulse(1'b1);
        check("in_menu", in_menu, 1'b0);
        check("range", setting.range, 4'h3);
        apb_read(OFS_STATUS, d, e);
        check("status mode", d[3:0], MODE_TIMER);
        check("status used", d[11], 1'b1);
        apb_read(8'h40, d, e);
        check("pslverr", e, 1'b1);
        // Bus writes must leave the programmed range alone
        apb_write(OFS_SETTING, 32'hFFFF_FFFF);
        apb_read(OFS_SETTING, d, e);
        check("setting range", d[3:0], 4'h3);
        // Enable low freezes the pin synchronisers, so a pulse then is lost
        @(posedge pclk);
        clk_en <= 1'b0;
        pins.pulse(1'b1);
        check("in_menu frozen", in_menu, 1'b0);
        @(posedge pclk);
        clk_en <= 1'b1;
        repeat (4) @(posedge pclk);
        check("in_menu thawed", in_menu, 1'b0);
        $display("timer test done");
    endtask : test_timer

    task automatic test_tach();
        restart(MODE_TACH);
        check("tbase", setting.tbase, TBASE_DEFAULT);
        pins.pulse(1'b1);
        check("mult", setting.mult, 20'h00000);
        check("blink_on", blink_on, 1'b1);
        for (int d = 0; d < 5; d++) begin
            check("blink_digit", blink_digit, d);
            repeat ((d == 0) ? 11 : d + 1) pins.pulse(1'b0);
            pins.pulse(1'b1);
        end
        check("mult", setting.mult, 20'h14321);
        check("point", setting.point, POINT_RESET);
        for (int i = 1; i <= 8; i++) begin
            pins.pulse(1'b0);
            check("point", setting.point, (4 + i) % 8);
        end
        pins.pulse(1'b1);
        check("tbase", setting.tbase, TBASE_ENTRY);
        pins.pulse(1'b0);
        check("tbase", setting.tbase, 3'h7);
        pins.pulse(1'b0);
        check("tbase", setting.tbase, 3'h0);
        check("rate_enable", rate_enable, 1'b0);
        pins.pulse(1'b0);
        pins.pulse(1'b1);
        check("in_menu", in_menu, 1'b0);
        check("tbase", setting.tbase, 3'h1);
        check("rate_enable", rate_enable, 1'b1);
        $display("tach test done");
    endtask : test_tach

    task automatic test_counter();
        restart(MODE_COUNTER);
        count_edge(1'b0, 1'b1, 0);
        count_edge(1'b0, 1'b0, 1);
        // Unused input tied high: rising edges of the used input count
        pins.set(MODE_COUNTER, 1'b1, 1'b0);
        count_edge(1'b1, 1'b1, 1);
        count_edge(1'b1, 1'b0, 0);
        pins.set(MODE_COUNTER, 1'b0, 1'b0);
        pins.pulse(1'b1);
        check("in_menu", in_menu, 1'b1);
        check("mult", setting.mult, 20'h00000);
        pins.pulse(1'b0);
        repeat (5) pins.pulse(1'b1);
        check("point", setting.point, POINT_RESET);
        pins.pulse(1'b0);
        pins.pulse(1'b1);
        check("in_menu", in_menu, 1'b0);
        check("point", setting.point, 3'h5);
        count_edge(1'b0, 1'b1, 1);
        count_edge(1'b0, 1'b0, 0);
        pins.set(MODE_COUNTER, 1'b1, 1'b0);
        count_edge(1'b1, 1'b1, 0);
        count_edge(1'b1, 1'b0, 1);
        pins.pulse(1'b1);
        check("mult", setting.mult, 20'h00001);
        $display("counter test done");
    endtask : test_counter

    initial begin
        test_timer();
        test_tach();
        test_counter();
        conclude();
    end
endmodule : tb_top
